// ===== logic/irb_builder.sv
// irb_builder.sv: top of the I/O sample record builder
// assumes: line pins are asynchronous; ADC words, remote query and received
// record pulses come from logic on ref_clk_i
//
// Contract
// - digital mask bits 0..14 name fixed lines
// - analog mask bits 0..3 channels, 7 supply
// - two state bytes only if any digital
// - two bytes per enabled analog channel
// - analog order channel zero up, supply last
// - line digital only for config 3,4,5
// - analog value 10 bits in two bytes
// - query captures everything at once, one record
// - local query to serial, remote over air
// - text mode ends each field with CR
// - record opens with sample count one
// - non-framed receiver discards remote records
// - multi-byte fields sent high byte first
`include "irb_defines.svh"
`default_nettype none
module irb_builder import irb_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`IRB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [`IRB_NLINES-1:0] lines_i,
  input wire irb_adc_t adc_i,
  input wire logic remote_query_i,
  input wire logic rx_rec_i,
  output irb_byte_t out_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic busy_o,
  output logic fwd_rec_o
);
  irb_cfg_t cfg;
  logic local_query;
  irb_state_t st, next_st, ret_st, next_ret_st, after;
  logic [2:0] ch, next_ch, cand_ch;
  logic [15:0] snap_dmask, next_snap_dmask, snap_dst, next_snap_dst;
  logic [7:0] snap_amask, next_snap_amask;
  irb_adc_t snap_an, next_snap_an;
  logic snap_text, next_snap_text, dest, next_dest;
  logic [`IRB_NLINES-1:0] line_s1, line_s2;
  logic [15:0] live_dmask;
  logic [7:0] live_amask;
  irb_byte_t push;
  logic push_valid, push_ready, field_end, adv, start, start_remote;
  logic [7:0] drop_cnt, next_drop_cnt;
  logic next_fwd;

  irb_apb u_apb (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .cfg_o(cfg),
    .query_o(local_query),
    .busy_i(busy_o),
    .drop_cnt_i(drop_cnt)
  );

  irb_skid u_skid (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_i(push),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .out_o(out_o),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i)
  );

  function automatic logic [2:0] line_cfg_of(input irb_cfg_t c, input int idx);
    line_cfg_of = c.line_cfg[idx*`IRB_CFG_W +: `IRB_CFG_W];
  endfunction

  // first enabled analog channel at or above 'from'; channel 4 is supply
  function automatic logic [2:0] next_chan(input logic [7:0] am, input logic [2:0] from);
    logic [2:0] r;
    r = `IRB_NCHAN;
    for (int i = int'(`IRB_SUPPLY_CH); i >= 0; i--) begin
      if (i >= int'(from)) begin
        if (i == int'(`IRB_SUPPLY_CH) ? am[`IRB_AMASK_SUPPLY] : am[i]) begin
          r = 3'(i);
        end
      end
    end
    next_chan = r;
  endfunction

  always_comb begin
    live_dmask = 16'h0;
    live_amask = 8'h0;
    for (int i = 0; i < `IRB_NLINES; i++) begin
      live_dmask[i] = line_cfg_of(cfg, i) == `IRB_CFG_DIN ||
                      line_cfg_of(cfg, i) == `IRB_CFG_DOUT_LO ||
                      line_cfg_of(cfg, i) == `IRB_CFG_DOUT_HI;
    end
    for (int i = 0; i < int'(`IRB_SUPPLY_CH); i++) begin
      live_amask[i] = line_cfg_of(cfg, i) == `IRB_CFG_ANALOG;
    end
    live_amask[`IRB_AMASK_SUPPLY] = cfg.supply_en;
  end

  // queries arriving while a record is in flight are dropped; local wins a tie
  assign start = (st == IRB_IDLE) && (local_query || remote_query_i);
  assign start_remote = !local_query && remote_query_i;
  assign adv = push_valid && push_ready;

  always_comb begin
    next_st = st;
    next_ret_st = ret_st;
    next_ch = ch;
    next_snap_dmask = snap_dmask;
    next_snap_amask = snap_amask;
    next_snap_dst = snap_dst;
    next_snap_an = snap_an;
    next_snap_text = snap_text;
    next_dest = dest;
    push = '0;
    push_valid = 1'b0;
    field_end = 1'b0;
    after = st;
    cand_ch = ch;
    case (st)
      IRB_IDLE: begin
        if (start) begin
          next_snap_dmask = live_dmask;
          next_snap_amask = live_amask;
          next_snap_dst = {1'b0, line_s2} & live_dmask;
          next_snap_an = adc_i;
          next_snap_text = !cfg.framed;
          next_dest = start_remote;
          next_st = IRB_CNT;
        end
      end
      IRB_CNT: begin
        push.data = `IRB_SET_COUNT;
        field_end = 1'b1;
        after = IRB_DMH;
      end
      IRB_DMH: begin
        push.data = {1'b0, snap_dmask[14:8]};
        after = IRB_DML;
      end
      IRB_DML: begin
        push.data = snap_dmask[7:0];
        field_end = 1'b1;
        after = IRB_AM;
      end
      IRB_AM: begin
        push.data = {snap_amask[`IRB_AMASK_SUPPLY], 3'h0, snap_amask[3:0]};
        field_end = 1'b1;
        cand_ch = next_chan(snap_amask, 3'h0);
        // state bytes only with digital lines
        if (snap_dmask != 16'h0) begin
          after = IRB_DSH;
        end else begin
          after = (cand_ch == `IRB_NCHAN) ? IRB_IDLE : IRB_ANH;
        end
      end
      IRB_DSH: begin
        push.data = snap_dst[15:8];
        after = IRB_DSL;
      end
      IRB_DSL: begin
        push.data = snap_dst[7:0];
        field_end = 1'b1;
        cand_ch = next_chan(snap_amask, 3'h0);
        after = (cand_ch == `IRB_NCHAN) ? IRB_IDLE : IRB_ANH;
      end
      IRB_ANH: begin
        push.data = {6'h0, snap_an[ch][`IRB_ADC_W-1:8]};
        after = IRB_ANL;
      end
      IRB_ANL: begin
        push.data = snap_an[ch][7:0];
        field_end = 1'b1;
        cand_ch = next_chan(snap_amask, 3'(ch + 3'h1));
        after = (cand_ch == `IRB_NCHAN) ? IRB_IDLE : IRB_ANH;
      end
      IRB_CRT: begin
        push.data = `IRB_CR;
        after = ret_st;
      end
      default: begin
        next_st = IRB_IDLE;
      end
    endcase
    push_valid = (st != IRB_IDLE) && (st <= IRB_CRT);
    push.dest = dest;
    push.last = (field_end && snap_text) ? 1'b0 : (after == IRB_IDLE);
    if (adv) begin
      next_ch = cand_ch;
      if (field_end && snap_text) begin
        next_st = IRB_CRT;
        next_ret_st = after;
      end else begin
        next_st = after;
      end
    end
  end

  always_comb begin
    next_drop_cnt = drop_cnt;
    next_fwd = rx_rec_i && cfg.framed;
    if (rx_rec_i && !cfg.framed && drop_cnt != 8'hff) begin
      next_drop_cnt = 8'(drop_cnt + 8'h1);
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= IRB_IDLE;
      ret_st <= IRB_IDLE;
      ch <= 3'h0;
      snap_dmask <= 16'h0;
      snap_amask <= 8'h0;
      snap_dst <= 16'h0;
      snap_an <= '0;
      snap_text <= 1'b0;
      dest <= 1'b0;
      line_s1 <= '0;
      line_s2 <= '0;
      busy_o <= 1'b0;
      drop_cnt <= 8'h0;
      fwd_rec_o <= 1'b0;
    end else begin
      st <= next_st;
      ret_st <= next_ret_st;
      ch <= next_ch;
      snap_dmask <= next_snap_dmask;
      snap_amask <= next_snap_amask;
      snap_dst <= next_snap_dst;
      snap_an <= next_snap_an;
      snap_text <= next_snap_text;
      dest <= next_dest;
      line_s1 <= lines_i;
      line_s2 <= line_s1;
      busy_o <= next_st != IRB_IDLE;
      drop_cnt <= next_drop_cnt;
      fwd_rec_o <= next_fwd;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_start;
    start;
  endsequence
  sequence s_cnt_sent;
    st == IRB_CNT && adv;
  endsequence
  sequence s_dmh_sent;
    st == IRB_DMH && adv;
  endsequence

  property p_count_one;
    st == IRB_CNT && push_valid |-> push.data == `IRB_SET_COUNT;
  endproperty
  a_count_one: assert property (p_count_one) else $error("count byte not one");

  property p_snapshot;
    s_start |=> st == IRB_CNT && snap_dmask == $past(live_dmask) && snap_an == $past(adc_i);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("query snapshot wrong");

  property p_dest;
    s_start |=> dest == $past(start_remote) ##1 push.dest == dest;
  endproperty
  a_dest: assert property (p_dest) else $error("reply path wrong");

  property p_cr_after_field;
    s_cnt_sent ##0 snap_text |=> st == IRB_CRT && push.data == `IRB_CR;
  endproperty
  a_cr_after_field: assert property (p_cr_after_field) else $error("missing CR");

  property p_msb_first;
    s_dmh_sent |=> st == IRB_DML && push.data == snap_dmask[7:0];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("mask byte order wrong");

  property p_rsvd_zero;
    (st == IRB_DMH |-> !push.data[7]) and (st == IRB_AM |-> push.data[6:4] == 3'h0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved mask bit set");

  property p_no_states;
    // ret_st covers the text path, where a CR sits between mask and next field
    st == IRB_AM && adv && snap_dmask == 16'h0 |=> st != IRB_DSH && ret_st != IRB_DSH;
  endproperty
  a_no_states: assert property (p_no_states) else $error("state bytes without lines");

  property p_analog_hi;
    st == IRB_ANH |-> push.data[7:2] == 6'h0 && ch < `IRB_NCHAN;
  endproperty
  a_analog_hi: assert property (p_analog_hi) else $error("analog high byte wide");

  property p_ascend;
    st == IRB_ANL && adv && !snap_text |=> st == IRB_IDLE || (st == IRB_ANH && ch > $past(ch));
  endproperty
  a_ascend: assert property (p_ascend) else $error("analog order wrong");

  property p_discard;
    rx_rec_i |=> fwd_rec_o == $past(cfg.framed);
  endproperty
  a_discard: assert property (p_discard) else $error("remote record forwarding wrong");
endmodule // irb_builder
`default_nettype wire

// ===== logic/irb_defines.svh
// irb_defines.svh: register map, field layout and record constants
// assumes: included by bare name from every design file of the record builder
`ifndef IRB_DEFINES_SVH
`define IRB_DEFINES_SVH

`define IRB_AW 8
`define IRB_OFF_CTRL 8'h00
`define IRB_OFF_CFG_LO 8'h04
`define IRB_OFF_CFG_HI 8'h08
`define IRB_OFF_CMD 8'h0c
`define IRB_OFF_STAT 8'h10
`define IRB_CTRL_FRAMED 0
`define IRB_CTRL_SUPPLY 1
`define IRB_CMD_QUERY 0
`define IRB_STAT_BUSY 0
`define IRB_STAT_DROP 8
`define IRB_LO_LINES 10
`define IRB_NLINES 15
`define IRB_CFG_W 3
`define IRB_CFG_ANALOG 3'h2
`define IRB_CFG_DIN 3'h3
`define IRB_CFG_DOUT_LO 3'h4
`define IRB_CFG_DOUT_HI 3'h5
`define IRB_NCHAN 3'h5
`define IRB_SUPPLY_CH 3'h4
`define IRB_AMASK_SUPPLY 7
`define IRB_SET_COUNT 8'h01
`define IRB_CR 8'h0d
`define IRB_ADC_W 10

`endif

// ===== logic/irb_pkg.sv
// irb_pkg.sv: types shared by the sample record builder files
// assumes: irb_defines.svh on the include path
`include "irb_defines.svh"
`default_nettype none
package irb_pkg;
  typedef enum logic [3:0] {
    IRB_IDLE = 4'h0,
    IRB_CNT = 4'h1,
    IRB_DMH = 4'h2,
    IRB_DML = 4'h3,
    IRB_AM = 4'h4,
    IRB_DSH = 4'h5,
    IRB_DSL = 4'h6,
    IRB_ANH = 4'h7,
    IRB_ANL = 4'h8,
    IRB_CRT = 4'h9
  } irb_state_t;
  typedef struct packed {
    logic dest;
    logic last;
    logic [7:0] data;
  } irb_byte_t;
  typedef struct packed {
    logic framed;
    logic supply_en;
    logic [`IRB_NLINES*`IRB_CFG_W-1:0] line_cfg;
  } irb_cfg_t;
  typedef logic [4:0][`IRB_ADC_W-1:0] irb_adc_t;
endpackage
`default_nettype wire

// ===== logic/irb_skid.sv
// irb_skid.sv: two-entry record byte buffer, outputs straight from flops
// assumes: one clock; sink may stall at any time
`include "irb_defines.svh"
`default_nettype none
module irb_skid import irb_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire irb_byte_t in_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output irb_byte_t out_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  irb_byte_t spare, next_spare, next_out;
  logic spare_v, next_spare_v, next_out_v;

  assign in_ready_o = !spare_v;

  always_comb begin
    next_out = out_o;
    next_out_v = out_valid_o;
    next_spare = spare;
    next_spare_v = spare_v;
    if (out_ready_i || !out_valid_o) begin
      if (spare_v) begin
        next_out = spare;
        next_out_v = 1'b1;
        next_spare_v = 1'b0;
      end else begin
        next_out = in_i;
        next_out_v = in_valid_i;
      end
    end else if (in_valid_i && !spare_v) begin
      // head stalled: park the word so nothing is lost
      next_spare = in_i;
      next_spare_v = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_o <= '0;
      out_valid_o <= 1'b0;
      spare <= '0;
      spare_v <= 1'b0;
    end else begin
      out_o <= next_out;
      out_valid_o <= next_out_v;
      spare <= next_spare;
      spare_v <= next_spare_v;
    end
  end
endmodule // irb_skid
`default_nettype wire

// ===== logic/irb_apb.sv
// irb_apb.sv: APB slave holding mode, line configuration and query command
// assumes: APB master on ref_clk_i; zero wait states, pready one cycle after setup
`include "irb_defines.svh"
`default_nettype none
module irb_apb import irb_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`IRB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output irb_cfg_t cfg_o,
  output logic query_o,
  input wire logic busy_i,
  input wire logic [7:0] drop_cnt_i
);
  localparam int HI_W = (`IRB_NLINES - `IRB_LO_LINES) * `IRB_CFG_W;
  localparam int LO_W = `IRB_LO_LINES * `IRB_CFG_W;
  irb_cfg_t next_cfg;
  logic [31:0] next_prdata, rd;
  logic next_pready, next_pslverr, next_query, hit, setup, access;

  always_comb begin
    setup = psel_i && !penable_i;
    access = psel_i && penable_i && pready_o;
    hit = 1'b1;
    rd = 32'h0;
    case (paddr_i)
      `IRB_OFF_CTRL: begin
        rd[`IRB_CTRL_FRAMED] = cfg_o.framed;
        rd[`IRB_CTRL_SUPPLY] = cfg_o.supply_en;
      end
      `IRB_OFF_CFG_LO: rd[LO_W-1:0] = cfg_o.line_cfg[LO_W-1:0];
      `IRB_OFF_CFG_HI: rd[HI_W-1:0] = cfg_o.line_cfg[LO_W+HI_W-1:LO_W];
      `IRB_OFF_CMD: rd = 32'h0;
      `IRB_OFF_STAT: begin
        rd[`IRB_STAT_BUSY] = busy_i;
        rd[`IRB_STAT_DROP +: 8] = drop_cnt_i;
      end
      default: hit = 1'b0;
    endcase
    next_pready = setup;
    next_pslverr = setup && !hit;
    next_prdata = (setup && !pwrite_i) ? rd : prdata_o;
    next_cfg = cfg_o;
    next_query = 1'b0;
    if (access && pwrite_i && !pslverr_o) begin
      case (paddr_i)
        `IRB_OFF_CTRL: begin
          next_cfg.framed = pwdata_i[`IRB_CTRL_FRAMED];
          next_cfg.supply_en = pwdata_i[`IRB_CTRL_SUPPLY];
        end
        `IRB_OFF_CFG_LO: next_cfg.line_cfg[LO_W-1:0] = pwdata_i[LO_W-1:0];
        `IRB_OFF_CFG_HI: next_cfg.line_cfg[LO_W+HI_W-1:LO_W] = pwdata_i[HI_W-1:0];
        `IRB_OFF_CMD: next_query = pwdata_i[`IRB_CMD_QUERY];
        default: next_query = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      cfg_o <= '0;
      query_o <= 1'b0;
    end else begin
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      cfg_o <= next_cfg;
      query_o <= next_query;
    end
  end
endmodule // irb_apb
`default_nettype wire

// ===== logic/irb_builder_unused_placeholder_never.sv
`default_nettype none
`default_nettype wire

// ===== bench/irb_sink.sv
// irb_sink.sv: far-side byte consumer for the record builder
// assumes: same clock as the builder; stall_i slows acceptance
`include "irb_defines.svh"
`default_nettype none
module irb_sink import irb_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire irb_byte_t byte_i,
  input wire logic valid_i,
  output logic ready_o,
  input wire logic stall_i
);
  timeunit 1ns;
  timeprecision 1ps;
  irb_byte_t got[$];
  logic [1:0] phase;
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase <= 2'h0;
      ready_o <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      // slow mode refuses half the time, so the buffer must hold words
      ready_o <= !stall_i || phase[1];
      if (valid_i && ready_o) begin
        got.push_back(byte_i);
      end
    end
  end
endmodule // irb_sink
`default_nettype wire

// ===== bench/irb_builder_test.sv
// irb_builder_test.sv: self-checking bench for the sample record builder
// assumes: APB answers with a handshake; sink model on the byte stream
`include "irb_defines.svh"
`default_nettype none
module irb_builder_test import irb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic pready_o, pslverr_o, remote_query_i, rx_rec_i, out_valid_o, out_ready_i;
  logic busy_o, fwd_rec_o, stall, framed, supply, org;
  logic [14:0] lines_i;
  irb_adc_t adc_i;
  irb_byte_t out_o;
  irb_byte_t exp_q[$];
  int cfg[15];
  int err_total, samples_checked;
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("BAD t=%0t got %0h exp %0h", $time, g, e); end end
  irb_builder irb_builder_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .lines_i(lines_i), .adc_i(adc_i),
    .remote_query_i(remote_query_i), .rx_rec_i(rx_rec_i), .out_o(out_o),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .busy_o(busy_o),
    .fwd_rec_o(fwd_rec_o));
  irb_sink irb_sink_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .byte_i(out_o),
    .valid_i(out_valid_o), .ready_o(out_ready_i), .stall_i(stall));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] d;
    logic er;
    apb(1'b0, a, 32'h0, d, er);
    `CHK(d, e)
    `CHK(er, ee)
  endtask
  task automatic put_cfg(input logic fm, input logic sp);
    logic [31:0] lo, hi, d;
    logic er;
    lo = '0;
    hi = '0;
    for (int i = 0; i < 10; i++) lo[3*i +: 3] = 3'(cfg[i]);
    for (int i = 10; i < 15; i++) hi[3*(i-10) +: 3] = 3'(cfg[i]);
    framed = fm;
    supply = sp;
    apb(1'b1, `IRB_OFF_CTRL, {30'h0, sp, fm}, d, er);
    apb(1'b1, `IRB_OFF_CFG_LO, lo, d, er);
    apb(1'b1, `IRB_OFF_CFG_HI, hi, d, er);
    rdchk(`IRB_OFF_CFG_HI, hi, 1'b0);
  endtask
  task automatic add(input logic [7:0] b, input logic endf);
    exp_q.push_back('{dest: org, last: 1'b0, data: b});
    // text mode closes each field with a carriage return
    if (endf && !framed) exp_q.push_back('{dest: org, last: 1'b0, data: `IRB_CR});
  endtask
  task automatic build_exp;
    logic [15:0] dm, ds;
    logic [7:0] am;
    dm = '0;
    am = '0;
    exp_q.delete();
    for (int i = 0; i < 15; i++) dm[i] = cfg[i] inside {3, 4, 5};
    for (int i = 0; i < 4; i++) am[i] = (cfg[i] == 2);
    am[7] = supply;
    ds = {1'b0, lines_i} & dm;
    add(`IRB_SET_COUNT, 1'b1);
    add(dm[15:8], 1'b0);
    add(dm[7:0], 1'b1);
    add(am, 1'b1);
    if (dm != 16'h0) begin
      add(ds[15:8], 1'b0);
      add(ds[7:0], 1'b1);
    end
    for (int i = 0; i < 5; i++) begin
      if (am[(i == 4) ? 7 : i]) begin
        add({6'h0, adc_i[i][9:8]}, 1'b0);
        add(adc_i[i][7:0], 1'b1);
      end
    end
    exp_q[$].last = 1'b1;
  endtask
  task automatic query(input logic remote);
    logic [31:0] d;
    logic er;
    org = remote;
    build_exp();
    if (remote) begin
      @(posedge ref_clk_i);
      remote_query_i <= 1'b1;
      @(posedge ref_clk_i);
      remote_query_i <= 1'b0;
    end else begin
      apb(1'b1, `IRB_OFF_CMD, 32'h1, d, er);
    end
    // a second request while busy must be dropped
    repeat (3) @(posedge ref_clk_i);
    `CHK(busy_o, 1'b1)
    remote_query_i <= 1'b1;
    @(posedge ref_clk_i);
    remote_query_i <= 1'b0;
  endtask
  task automatic check_rec;
    int n;
    logic [15:0] raw;
    n = 0;
    while (irb_sink_inst.got.size() < exp_q.size() && n < 500) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 500) begin
      err_total++;
      tally_and_finish();
    end
    repeat (30) @(posedge ref_clk_i);
    `CHK(busy_o, 1'b0)
    `CHK(irb_sink_inst.got.size(), exp_q.size())
    foreach (exp_q[i]) begin
      if (i < irb_sink_inst.got.size()) `CHK(irb_sink_inst.got[i], exp_q[i])
    end
    if (framed) begin
      // receiver side: channel zero reading, the framed run's seventh byte, to millivolts
      raw = {irb_sink_inst.got[6].data, irb_sink_inst.got[7].data};
      `CHK((32'(raw) * 32'd1200) / 32'd1024, 32'd1143)
    end
    irb_sink_inst.got.delete();
  endtask
  task automatic pulse_rx(input logic ef);
    @(posedge ref_clk_i);
    rx_rec_i <= 1'b1;
    @(posedge ref_clk_i);
    rx_rec_i <= 1'b0;
    @(posedge ref_clk_i);
    `CHK(fwd_rec_o, ef)
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = !ref_clk_i;
  end
  initial begin
    {psel_i, penable_i, pwrite_i, remote_query_i, rx_rec_i, stall, org} = '0;
    paddr_i = '0;
    pwdata_i = '0;
    lines_i = '0;
    adc_i = {10'h155, 10'h3ff, 10'h2aa, 10'h124, 10'h3d0};
    err_total = 0;
    samples_checked = 0;
    sys_rst_i = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rdchk(`IRB_OFF_CTRL, 32'h0, 1'b0);
    rdchk(`IRB_OFF_STAT, 32'h0, 1'b0);
    rdchk(8'h14, 32'h0, 1'b1);
    foreach (cfg[i]) cfg[i] = 0;
    cfg[0] = 2; cfg[1] = 2; cfg[2] = 3; cfg[3] = 2; cfg[5] = 4; cfg[6] = 1;
    cfg[7] = 5; cfg[10] = 5; cfg[14] = 3;
    lines_i <= 15'h5ca5;
    stall <= 1'b1;
    put_cfg(1'b1, 1'b1);
    // framed, stalled sink, supply last
    query(1'b0);
    check_rec();
    foreach (cfg[i]) cfg[i] = 0;
    cfg[2] = 2; cfg[6] = 1; cfg[8] = 2; cfg[9] = 6; cfg[11] = 7;
    stall <= 1'b0;
    put_cfg(1'b0, 1'b0);
    // text mode, no digital lines at all
    query(1'b1);
    check_rec();
    foreach (cfg[i]) cfg[i] = 0;
    cfg[0] = 2; cfg[3] = 2; cfg[13] = 3;
    lines_i <= 15'h2001;
    stall <= 1'b1;
    put_cfg(1'b0, 1'b1);
    query(1'b0);
    check_rec();
    pulse_rx(1'b0);
    rdchk(`IRB_OFF_STAT, 32'h100, 1'b0);
    put_cfg(1'b1, 1'b1);
    pulse_rx(1'b1);
    tally_and_finish();
  end
  `undef CHK
endmodule // irb_builder_test
`default_nettype wire
